// ### hcctl_host_ctrl.sv
/*
 * Host controller control register, bits 31 to 20, as a set/clear pair,
 * with the response gating and event flagging it steers.
 * Assumes a one-cycle strobe register port, requests from the link layer
 * as one-cycle pulses, and resets synchronous to clock.
 */
// Operation
// - Register reached at set offset 50h and clear offset 54h.
// - Image valid one: config ROM block reads and atomic update answered.
// - Image valid zero: config ROM block reads get ack_type_error.
// - Bus reset with image valid zero: mapping, header, options not updated.
// - Image valid set only while link on is zero; else ignored.
// - Image valid cleared only by system reset, soft reset, fetch error.
// - Swap disable decides byte swapping of DMA data accesses.
// - Late ack enable makes other async packets get ack_tardy.
// - Every ack_tardy sent sets the ack_tardy event bit.
// - Reserved bits 28-24 and 21-20 read as zero.
// - Enhance permit is read-only, default one, loaded from EEPROM.
// - Enhance permit returned to default one only by global reset.
// - Link on zero disconnects the device from the bus at once.
`timescale 1ns/1ps
module hcctl_host_ctrl
    import hcctl_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic soft_rst,
    input wire logic global_reset,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic link_on,
    input wire logic eeprom_load,
    input wire logic eeprom_permit,
    input wire logic fetch_error,
    input wire logic bus_reset,
    input wire logic req_valid,
    input wire logic req_rom_block_read,
    input wire logic req_bus_access,
    output logic [1:0] ack_code,
    output logic ack_valid,
    output logic rom_regs_update,
    output logic phys_rom_enable,
    output logic byte_swap_en,
    output logic phy_enhance_active,
    output logic irq
);
    logic rst;
    logic wr_set;
    logic wr_clear;
    logic config_rom_image_valid;
    logic swap_disable;
    logic late_ack_enable;
    logic phy_enhance_on;
    logic phy_enhance_config_permit_reg;
    logic [HCCTL_IRQ_W-1:0] irq_status_reg;
    logic [HCCTL_IRQ_W-1:0] irq_mask_reg;
    logic [HCCTL_IRQ_W-1:0] irq_event;
    logic [31:0] ctrl_view;
    hcctl_state_t state_reg;
    hcctl_state_t state_next;
    logic rom_req_reg;
    logic bus_req_reg;
    logic tardy_sent;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    assign rst = sys_rst || soft_rst;
    assign wr_set = reg_write && (reg_addr == HCCTL_OFF_SET);
    assign wr_clear = reg_write && (reg_addr == HCCTL_OFF_CLEAR);

    // ------------------------------------------------------------
    // Control flags
    // ------------------------------------------------------------
    // Image valid: software may only set it while the link is off, and
    // software cannot clear it; only resets and fetch errors do.
    hcctl_set_clear_bit #(.RESET_VALUE(1'h0)) u_image_valid (
        .clock(clock),
        .rst(rst),
        .set_req(wr_set && reg_wdata[HCCTL_BIT_IMAGE_VALID]),
        .set_allow(!link_on),
        .clear_req(fetch_error),
        .flag_reg(config_rom_image_valid)
    );

    hcctl_set_clear_bit #(.RESET_VALUE(1'h0)) u_swap_disable (
        .clock(clock),
        .rst(rst),
        .set_req(wr_set && reg_wdata[HCCTL_BIT_SWAP_DISABLE]),
        .set_allow(1'h1),
        .clear_req(wr_clear && reg_wdata[HCCTL_BIT_SWAP_DISABLE]),
        .flag_reg(swap_disable)
    );

    hcctl_set_clear_bit #(.RESET_VALUE(1'h0)) u_late_ack (
        .clock(clock),
        .rst(rst),
        .set_req(wr_set && reg_wdata[HCCTL_BIT_LATE_ACK]),
        .set_allow(1'h1),
        .clear_req(wr_clear && reg_wdata[HCCTL_BIT_LATE_ACK]),
        .flag_reg(late_ack_enable)
    );

    hcctl_set_clear_bit #(.RESET_VALUE(1'h0)) u_phy_on (
        .clock(clock),
        .rst(rst),
        .set_req(wr_set && reg_wdata[HCCTL_BIT_PHY_ON]),
        .set_allow(1'h1),
        .clear_req(wr_clear && reg_wdata[HCCTL_BIT_PHY_ON]),
        .flag_reg(phy_enhance_on)
    );

    // Permit bit: untouched by system and soft reset
    always_ff @(posedge clock) begin
        if (global_reset) begin
            phy_enhance_config_permit_reg <= HCCTL_PERMIT_DEFAULT;
        end else if (eeprom_load) begin
            phy_enhance_config_permit_reg <= eeprom_permit;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        ctrl_view = 32'h0000_0000;
        ctrl_view[HCCTL_BIT_IMAGE_VALID] = config_rom_image_valid;
        ctrl_view[HCCTL_BIT_SWAP_DISABLE] = swap_disable;
        ctrl_view[HCCTL_BIT_LATE_ACK] = late_ack_enable;
        ctrl_view[HCCTL_BIT_PERMIT] = phy_enhance_config_permit_reg;
        ctrl_view[HCCTL_BIT_PHY_ON] = phy_enhance_on;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            case (reg_addr)
                HCCTL_OFF_SET, HCCTL_OFF_CLEAR: begin
                    reg_rdata <= ctrl_view;
                end
                HCCTL_OFF_IRQ_STATUS: begin
                    reg_rdata <= {30'h0000_0000, irq_status_reg};
                end
                HCCTL_OFF_IRQ_MASK: begin
                    reg_rdata <= {30'h0000_0000, irq_mask_reg};
                end
                default: begin
                    reg_rdata <= 32'h0000_0000;
                end
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Request answering
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            HCCTL_IDLE: begin
                if (req_valid && link_on) begin
                    state_next = HCCTL_DECIDE;
                end
            end
            HCCTL_DECIDE: begin
                state_next = HCCTL_ANSWER;
            end
            HCCTL_ANSWER: begin
                state_next = HCCTL_IDLE;
            end
            default: begin
                state_next = HCCTL_IDLE;
            end
        endcase
        if (!link_on) begin
            state_next = HCCTL_IDLE;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= HCCTL_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rom_req_reg <= 1'h0;
            bus_req_reg <= 1'h0;
        end else if (state_reg == HCCTL_IDLE && req_valid) begin
            rom_req_reg <= req_rom_block_read;
            bus_req_reg <= req_bus_access;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ack_code <= HCCTL_ACK_NONE;
            ack_valid <= 1'h0;
        end else if (state_reg == HCCTL_DECIDE && link_on) begin
            ack_valid <= 1'h1;
            if (rom_req_reg && !config_rom_image_valid) begin
                ack_code <= HCCTL_ACK_TYPE_ERROR;
            end else if (late_ack_enable && !bus_req_reg && !rom_req_reg) begin
                ack_code <= HCCTL_ACK_TARDY;
            end else begin
                ack_code <= HCCTL_ACK_NORMAL;
            end
        end else begin
            ack_code <= HCCTL_ACK_NONE;
            ack_valid <= 1'h0;
        end
    end

    assign tardy_sent = ack_valid && (ack_code == HCCTL_ACK_TARDY);

    // ------------------------------------------------------------
    // Steering outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            rom_regs_update <= 1'h0;
            phys_rom_enable <= 1'h0;
            byte_swap_en <= 1'h1;
            phy_enhance_active <= 1'h0;
        end else begin
            rom_regs_update <= bus_reset && config_rom_image_valid && link_on;
            phys_rom_enable <= config_rom_image_valid && link_on;
            byte_swap_en <= !swap_disable;
            phy_enhance_active <= phy_enhance_on && phy_enhance_config_permit_reg;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    always_comb begin
        irq_event = '0;
        irq_event[HCCTL_IRQ_LATE_ACK] = tardy_sent;
        irq_event[HCCTL_IRQ_FETCH_ERR] = fetch_error;
    end

    // Event set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_status_reg <= '0;
        end else if (reg_write && reg_addr == HCCTL_OFF_IRQ_STATUS) begin
            irq_status_reg <= (irq_status_reg & ~reg_wdata[HCCTL_IRQ_W-1:0]) | irq_event;
        end else begin
            irq_status_reg <= irq_status_reg | irq_event;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_mask_reg <= '0;
        end else if (reg_write && reg_addr == HCCTL_OFF_IRQ_MASK) begin
            irq_mask_reg <= reg_wdata[HCCTL_IRQ_W-1:0];
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_image_valid_lock: assert property (@(posedge clock) disable iff (rst)
        (link_on && !config_rom_image_valid && !fetch_error) |=> !config_rom_image_valid)
        else $error("image valid set while link on");

    a_image_valid_hold: assert property (@(posedge clock) disable iff (rst)
        (config_rom_image_valid && !fetch_error) |=> config_rom_image_valid)
        else $error("image valid cleared without cause");

    a_rom_type_err: assert property (@(posedge clock) disable iff (rst)
        (state_reg == HCCTL_DECIDE && link_on && rom_req_reg && !config_rom_image_valid)
        |=> (ack_valid && ack_code == HCCTL_ACK_TYPE_ERROR))
        else $error("rom read not refused");

    a_tardy_event: assert property (@(posedge clock) disable iff (rst)
        tardy_sent |=> irq_status_reg[HCCTL_IRQ_LATE_ACK])
        else $error("tardy event not flagged");

    a_tardy_answer: assert property (@(posedge clock) disable iff (rst)
        (state_reg == HCCTL_DECIDE && link_on && late_ack_enable && !rom_req_reg
        && !bus_req_reg) |=> ack_code == HCCTL_ACK_TARDY)
        else $error("late ack not sent");

    a_reserved_zero: assert property (@(posedge clock) disable iff (sys_rst)
        $past(reg_read) && $past(reg_addr) == HCCTL_OFF_SET
        |-> (reg_rdata[28:24] == 5'h00 && reg_rdata[21:20] == 2'h0))
        else $error("reserved bits not zero");

    a_rom_update_gate: assert property (@(posedge clock) disable iff (rst)
        (bus_reset && !config_rom_image_valid) |=> !rom_regs_update)
        else $error("rom regs updated while invalid");

    a_link_off_quiet: assert property (@(posedge clock) disable iff (rst)
        !link_on |=> (state_reg == HCCTL_IDLE && !ack_valid))
        else $error("activity while link off");

    a_permit_keep: assert property (@(posedge clock)
        (!global_reset && !eeprom_load) |=> $stable(phy_enhance_config_permit_reg))
        else $error("permit changed without cause");

    a_swap_follow: assert property (@(posedge clock) disable iff (rst)
        swap_disable |=> !byte_swap_en)
        else $error("swap not disabled");

    a_swap_on: assert property (@(posedge clock) disable iff (rst)
        !swap_disable |=> byte_swap_en)
        else $error("swap not enabled");

    a_permit_global: assert property (@(posedge clock)
        global_reset |=> phy_enhance_config_permit_reg == HCCTL_PERMIT_DEFAULT)
        else $error("permit not restored by global reset");

    a_permit_load: assert property (@(posedge clock)
        (!global_reset && eeprom_load)
        |=> phy_enhance_config_permit_reg == $past(eeprom_permit))
        else $error("permit not loaded");

    a_rom_phys_gate: assert property (@(posedge clock) disable iff (rst)
        (config_rom_image_valid && link_on) |=> phys_rom_enable)
        else $error("rom responses not enabled");

    a_rom_phys_off: assert property (@(posedge clock) disable iff (rst)
        !config_rom_image_valid |=> !phys_rom_enable)
        else $error("rom responses on while invalid");

    a_status_sticky: assert property (@(posedge clock) disable iff (rst)
        (irq_status_reg[HCCTL_IRQ_LATE_ACK]
        && !(reg_write && reg_addr == HCCTL_OFF_IRQ_STATUS))
        |=> irq_status_reg[HCCTL_IRQ_LATE_ACK])
        else $error("tardy event lost");

    a_rdata_idle: assert property (@(posedge clock) disable iff (sys_rst)
        !reg_read |=> reg_rdata == '0)
        else $error("read data not zero when idle");
endmodule : hcctl_host_ctrl

// ### hcctl_pkg.sv
/*
 * Package for the host controller control set/clear register block:
 * offsets, bit positions, reset values, link response codes.
 * Assumes a 32-bit plain register port and a single 200 MHz clock.
 */
package hcctl_pkg;
    localparam logic [7:0] HCCTL_OFF_SET = 8'h50;
    localparam logic [7:0] HCCTL_OFF_CLEAR = 8'h54;
    localparam logic [7:0] HCCTL_OFF_IRQ_STATUS = 8'h58;
    localparam logic [7:0] HCCTL_OFF_IRQ_MASK = 8'h5c;

    localparam int HCCTL_BIT_IMAGE_VALID = 31;
    localparam int HCCTL_BIT_SWAP_DISABLE = 30;
    localparam int HCCTL_BIT_LATE_ACK = 29;
    localparam int HCCTL_BIT_PERMIT = 23;
    localparam int HCCTL_BIT_PHY_ON = 22;
    localparam int HCCTL_BIT_LINK_ON = 17;

    localparam logic HCCTL_PERMIT_DEFAULT = 1'h1;

    // Interrupt status bits
    localparam int HCCTL_IRQ_LATE_ACK = 0;
    localparam int HCCTL_IRQ_FETCH_ERR = 1;
    localparam int HCCTL_IRQ_W = 2;

    // Acknowledge codes offered to the link layer
    typedef enum logic [1:0] {
        HCCTL_ACK_NORMAL = 2'h0,
        HCCTL_ACK_TARDY = 2'h1,
        HCCTL_ACK_TYPE_ERROR = 2'h3,
        HCCTL_ACK_NONE = 2'h2
    } hcctl_ack_t;

    // Response to one incoming request
    typedef enum logic [1:0] {
        HCCTL_IDLE = 2'h0,
        HCCTL_DECIDE = 2'h1,
        HCCTL_ANSWER = 2'h3
    } hcctl_state_t;
endpackage : hcctl_pkg

// ### hcctl_set_clear_bit.sv
/*
 * One read/set/clear flag with its own reset value and a lock on setting.
 * Assumes set and clear strobes come from the register decoder.
 */
`timescale 1ns/1ps
module hcctl_set_clear_bit #(
    parameter logic RESET_VALUE = 1'h0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic set_req,
    input wire logic set_allow,
    input wire logic clear_req,
    output logic flag_reg
);
    // A set in the same cycle as a clear wins
    always_ff @(posedge clock) begin
        if (rst) begin
            flag_reg <= RESET_VALUE;
        end else if (set_req && set_allow) begin
            flag_reg <= 1'h1;
        end else if (clear_req) begin
            flag_reg <= 1'h0;
        end
    end
endmodule : hcctl_set_clear_bit

// ### hcctl_remote_node.sv
/*
 * Model of a remote 1394 node that sends asynchronous requests to the
 * host control block and records the acknowledge that comes back.
 * Assumes the bench raises go for one cycle per request, at least
 * six cycles apart, and that all signals are sampled on clock.
 */
`timescale 1ns/1ps
module hcctl_remote_node (
    input wire logic clock,
    input wire logic go,
    input wire logic kind_rom,
    input wire logic kind_bus,
    output logic req_valid,
    output logic req_rom_block_read,
    output logic req_bus_access,
    input wire logic [1:0] ack_code,
    input wire logic ack_valid,
    output logic ack_seen,
    output logic [1:0] ack_last,
    output logic [7:0] ack_delay
);
    logic [7:0] age_reg;

    initial begin
        req_valid = 1'h0;
        req_rom_block_read = 1'h0;
        req_bus_access = 1'h0;
        ack_seen = 1'h0;
        ack_last = 2'h0;
        ack_delay = 8'h0;
        age_reg = 8'hff;
    end

    // ----------------------------------------------------------------
    // Request issue; kind lines toggle while no request is on them
    // ----------------------------------------------------------------
    always @(posedge clock) begin
        req_valid <= 1'h0;
        if (go) begin
            req_valid <= 1'h1;
            req_rom_block_read <= kind_rom;
            req_bus_access <= kind_bus;
            age_reg <= 8'h0;
            ack_seen <= 1'h0;
        end else begin
            req_rom_block_read <= ~req_rom_block_read;
            req_bus_access <= ~req_bus_access;
            if (age_reg != 8'hff) begin
                age_reg <= age_reg + 8'h1;
            end
        end
        if (ack_valid) begin
            ack_seen <= 1'h1;
            ack_last <= ack_code;
            ack_delay <= age_reg;
        end
    end
endmodule : hcctl_remote_node

// ### hcctl_host_ctrl_test.sv
/*
 * Self-checking bench for the host control set/clear register block.
 * Assumes the register port and request link timing of the block and
 * a remote node model on the request side.
 */
`timescale 1ns/1ps
module hcctl_host_ctrl_test;
    import hcctl_pkg::*;

    logic clock = 1'h0;
    logic sys_rst = 1'h1;
    logic soft_rst = 1'h0;
    logic global_reset = 1'h1;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'h0;
    logic reg_read = 1'h0;
    logic [31:0] reg_rdata;
    logic link_on = 1'h0;
    logic eeprom_load = 1'h0;
    logic eeprom_permit = 1'h1;
    logic fetch_error = 1'h0;
    logic bus_reset = 1'h0;
    logic go = 1'h0;
    logic kind_rom = 1'h0;
    logic kind_bus = 1'h0;
    logic req_valid, req_rom_block_read, req_bus_access, ack_valid, ack_seen;
    logic [1:0] ack_code, ack_last;
    logic [7:0] ack_delay;
    logic rom_regs_update, phys_rom_enable, byte_swap_en, phy_enhance_active, irq;
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;

    always #2.5 clock = ~clock;

    hcctl_host_ctrl hcctl_host_ctrl_inst (.clock(clock), .sys_rst(sys_rst),
        .soft_rst(soft_rst), .global_reset(global_reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .link_on(link_on), .eeprom_load(eeprom_load),
        .eeprom_permit(eeprom_permit), .fetch_error(fetch_error),
        .bus_reset(bus_reset), .req_valid(req_valid),
        .req_rom_block_read(req_rom_block_read), .req_bus_access(req_bus_access),
        .ack_code(ack_code), .ack_valid(ack_valid), .rom_regs_update(rom_regs_update),
        .phys_rom_enable(phys_rom_enable), .byte_swap_en(byte_swap_en),
        .phy_enhance_active(phy_enhance_active), .irq(irq));

    hcctl_remote_node hcctl_remote_node_inst (.clock(clock), .go(go),
        .kind_rom(kind_rom), .kind_bus(kind_bus), .req_valid(req_valid),
        .req_rom_block_read(req_rom_block_read), .req_bus_access(req_bus_access),
        .ack_code(ack_code), .ack_valid(ack_valid), .ack_seen(ack_seen),
        .ack_last(ack_last), .ack_delay(ack_delay));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task conclude;
        if (error_cnt == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge clock);
        reg_write <= 1'h0;
        #1;
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge clock);
        reg_read <= 1'h0;
        #1;
        chk("reg_rdata", exp, reg_rdata);
    endtask : rd

    task req(input logic rom, input logic bus, input logic exp_seen, input logic [1:0] exp);
        @(posedge clock);
        go <= 1'h1;
        kind_rom <= rom;
        kind_bus <= bus;
        @(posedge clock);
        go <= 1'h0;
        repeat (6) @(posedge clock);
        #1;
        chk("ack_seen", {31'h0, exp_seen}, {31'h0, ack_seen});
        if (exp_seen) begin
            chk("ack_code", {30'h0, exp}, {30'h0, ack_last});
            chk("ack_delay", 32'h2, {24'h0, ack_delay});
        end
    endtask : req

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            conclude;
        end
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clock);
        sys_rst <= 1'h0;
        global_reset <= 1'h0;
        rd(HCCTL_OFF_SET, 32'h0080_0000);
        chk("byte_swap_en", 32'h1, {31'h0, byte_swap_en});
        wr(HCCTL_OFF_SET, 32'hffbf_ffff);
        rd(HCCTL_OFF_SET, 32'he080_0000);
        @(posedge clock);
        link_on <= 1'h1;
        wr(HCCTL_OFF_SET, 32'h0040_0000);
        rd(HCCTL_OFF_SET, 32'he0c0_0000);
        rd(HCCTL_OFF_CLEAR, 32'he0c0_0000);
        chk("byte_swap_en", 32'h0, {31'h0, byte_swap_en});
        chk("phy_enhance_active", 32'h1, {31'h0, phy_enhance_active});
        @(posedge clock);
        eeprom_permit <= 1'h0;
        eeprom_load <= 1'h1;
        @(posedge clock);
        eeprom_load <= 1'h0;
        wr(HCCTL_OFF_SET, 32'h0080_0000);
        rd(HCCTL_OFF_SET, 32'he040_0000);
        chk("phy_enhance_active", 32'h0, {31'h0, phy_enhance_active});
        wr(HCCTL_OFF_CLEAR, 32'hffbf_ffff);
        rd(HCCTL_OFF_SET, 32'h8040_0000);
        chk("byte_swap_en", 32'h1, {31'h0, byte_swap_en});
        @(posedge clock);
        soft_rst <= 1'h1;
        @(posedge clock);
        soft_rst <= 1'h0;
        rd(HCCTL_OFF_SET, 32'h0000_0000);
        @(posedge clock);
        global_reset <= 1'h1;
        @(posedge clock);
        global_reset <= 1'h0;
        rd(HCCTL_OFF_SET, 32'h0080_0000);
        @(posedge clock);
        link_on <= 1'h1;
        wr(HCCTL_OFF_SET, 32'h8000_0000);
        rd(HCCTL_OFF_SET, 32'h0080_0000);
        req(1'h1, 1'h0, 1'h1, HCCTL_ACK_TYPE_ERROR);
        chk("phys_rom_enable", 32'h0, {31'h0, phys_rom_enable});
        @(posedge clock);
        bus_reset <= 1'h1;
        @(posedge clock);
        bus_reset <= 1'h0;
        #1 chk("rom_regs_update", 32'h0, {31'h0, rom_regs_update});
        @(posedge clock);
        link_on <= 1'h0;
        wr(HCCTL_OFF_SET, 32'h8000_0000);
        @(posedge clock);
        link_on <= 1'h1;
        repeat (2) @(posedge clock);
        #1 chk("phys_rom_enable", 32'h1, {31'h0, phys_rom_enable});
        req(1'h1, 1'h0, 1'h1, HCCTL_ACK_NORMAL);
        @(posedge clock);
        bus_reset <= 1'h1;
        @(posedge clock);
        bus_reset <= 1'h0;
        #1 chk("rom_regs_update", 32'h1, {31'h0, rom_regs_update});
        wr(HCCTL_OFF_SET, 32'h2000_0000);
        req(1'h0, 1'h0, 1'h1, HCCTL_ACK_TARDY);
        req(1'h0, 1'h1, 1'h1, HCCTL_ACK_NORMAL);
        rd(HCCTL_OFF_IRQ_STATUS, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        wr(HCCTL_OFF_IRQ_MASK, 32'h1);
        chk("irq", 32'h1, {31'h0, irq});
        wr(HCCTL_OFF_IRQ_STATUS, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        @(posedge clock);
        link_on <= 1'h0;
        req(1'h0, 1'h0, 1'h0, HCCTL_ACK_NORMAL);
        @(posedge clock);
        fetch_error <= 1'h1;
        @(posedge clock);
        fetch_error <= 1'h0;
        rd(HCCTL_OFF_SET, 32'h2080_0000);
        rd(HCCTL_OFF_IRQ_STATUS, 32'h2);
        rd(8'h60, 32'h0);
        conclude;
    end
endmodule : hcctl_host_ctrl_test
